// File: hw/ces_pkg.sv
// constants for the controller enable and status register bank
`default_nettype none
package ces_pkg;
	// register byte offsets
	localparam logic [7:0] OFF_CONFIG = 8'h14;
	localparam logic [7:0] OFF_STATUS = 8'h1C;
	localparam logic [7:0] OFF_ADMIN_SIZES = 8'h24;
	// configuration fields
	localparam int CC_EN_BIT = 0;
	localparam int CC_LO_LSB = 4;
	localparam int CC_LO_W = 10;
	localparam int CC_SHN_LSB = 14;
	localparam int CC_HI_LSB = 16;
	localparam int CC_HI_W = 8;
	// status fields
	localparam int ST_RDY_BIT = 0;
	localparam int ST_CFS_BIT = 1;
	localparam int ST_SHUTDOWN_STATE_LSB = 2;
	localparam int ST_SSR_BIT = 4;
	localparam int ST_PP_BIT = 5;
	// reset values and masks
	localparam logic [CC_LO_W-1:0] CC_LO_RST = 10'h000;
	localparam logic [CC_HI_W-1:0] CC_HI_RST = 8'h00;
	localparam logic [31:0] AQA_RST = 32'h0000_0000;
	localparam logic [31:0] AQA_MASK = 32'h0FFF_0FFF;
	localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
	// shutdown request codes
	typedef enum logic [1:0] {
		SHN_NONE = 2'b00,
		SHN_NORMAL = 2'b01,
		SHN_ABRUPT = 2'b10,
		SHN_RSVD = 2'b11
	} ces_shn_t;
	// shutdown state codes
	typedef enum logic [1:0] {
		SHUTDOWN_STATE_NORMAL = 2'b00,
		SHUTDOWN_STATE_BUSY = 2'b01,
		SHUTDOWN_STATE_DONE = 2'b10,
		SHUTDOWN_STATE_RSVD = 2'b11
	} ces_shutdown_state_t;
	// enable sequencer states
	typedef enum logic [1:0] {
		ST_OFF = 2'b00,
		ST_INIT = 2'b01,
		ST_READY = 2'b10,
		ST_RESET = 2'b11
	} ces_state_t;
endpackage : ces_pkg
`default_nettype wire

// File: hw/ces_top.sv
// controller enable and status register bank with classic wishbone slave
// How it works
// R1 - enable set: process commands on doorbells
// R2 - enable clear: no processing, no completions
// R3 - enable falling edge triggers controller reset
// R4 - controller reset spares admin queue registers
// R5 - posted completions lose no data on reset
// R6 - ready clears with enable, reads zero then
// R7 - ready sets when doorbells can be accepted
// R8 - host toggles enable only matching ready
// R9 - host writes admin queue registers only disabled
// R10 - paused flag shows temporary processing stop
// R11 - subsystem reset seen initialised by reset kind
// R12 - subsystem reset seen valid only if capable
// R13 - shutdown state reports shutdown progress
// R14 - after shutdown done host must reset
// R15 - fatal flag set on unreportable fatal error
// R16 - host submits nothing before ready reads one
// R17 - host waits ready wait limit for ready
// R18 - shutdown request field encodes shutdown kind
// R19 - shutdown state busy, done, cleared by reset
// R20 - reserved status bits read zero, writes ignored
`default_nettype none
module ces_top
	import ces_pkg::*;
#(
	parameter bit SSR_CAPABLE = 1'b1,
	parameter int ADDR_W = 8
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [ADDR_W-1:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input wire logic init_done_i,
	input wire logic idle_i,
	input wire logic pause_i,
	input wire logic fatal_err_i,
	input wire logic init_fatal_i,
	input wire logic warm_ssr_i,
	input wire logic fw_activated_i,
	input wire logic shutdown_done_i,
	output logic cmd_en_o,
	output logic post_en_o,
	output logic queue_reset_o,
	output logic flush_req_o,
	output logic shutdown_busy_o
);

	if (ADDR_W < 6 || ADDR_W > 8) begin : g_bad_addr_w
		$error("ADDR_W must lie between 6 and 8");
	end

	////////////////////////////////////////////////////////////////////
	// state
	ces_state_t st_q, st_d;
	ces_shutdown_state_t shutdown_state_q, shutdown_state_d;
	ces_shn_t shn_q, shn_d;
	logic en_q, en_d, rdy_q, rdy_d, ack_q, boot_q, ssr_q, cfs_q, pp_q;
	logic [CC_LO_W-1:0] lo_q, lo_d;
	logic [CC_HI_W-1:0] hi_q, hi_d;
	logic [31:0] aqa_q, rd_q, cc_word, st_word, cc_new, wd_new;
	logic [7:0] off;
	logic wr, wr_cc, wr_st, wr_aqa, en_fall, cmd_d, post_d;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[8*b+:8] = nw[8*b+:8];
			end
		end
		return r;
	endfunction : merge

	assign off = 8'(adr_i);
	assign cc_word = {8'h00, hi_q, shn_q, lo_q, 3'b000, en_q};
	assign st_word = {26'h0, pp_q & en_q, ssr_q & SSR_CAPABLE, shutdown_state_q, cfs_q, rdy_q}; // R10 R12 R20
	assign cc_new = merge(cc_word, dat_i, sel_i);

	////////////////////////////////////////////////////////////////////
	// wishbone slave: ack one cycle after request, write at ack edge
	assign wr = cyc_i && stb_i && we_i && ack_q;
	assign wr_cc = wr && off == OFF_CONFIG;
	assign wr_st = wr && off == OFF_STATUS;
	assign wr_aqa = wr && off == OFF_ADMIN_SIZES;
	assign wd_new = merge(aqa_q, dat_i, sel_i) & AQA_MASK;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= cyc_i && stb_i && !ack_q;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rd_q <= UNMAPPED_DATA;
		end else if (cyc_i && stb_i && !ack_q) begin
			case (off)
				OFF_CONFIG: rd_q <= cc_word;
				OFF_STATUS: rd_q <= st_word;
				OFF_ADMIN_SIZES: rd_q <= aqa_q;
				default: rd_q <= UNMAPPED_DATA;
			endcase
		end
	end

	assign dat_o = rd_q;
	assign ack_o = ack_q;

	////////////////////////////////////////////////////////////////////
	// next state of enable, sequencer and configuration fields
	always_comb begin
		en_d = en_q;
		shn_d = shn_q;
		lo_d = lo_q;
		hi_d = hi_q;
		if (wr_cc) begin
			en_d = cc_new[CC_EN_BIT];
			shn_d = ces_shn_t'(cc_new[CC_SHN_LSB+:2]); // R18
			lo_d = cc_new[CC_LO_LSB+:CC_LO_W];
			hi_d = cc_new[CC_HI_LSB+:CC_HI_W];
		end
		en_fall = en_q && !en_d;
		if (en_fall) begin
			shn_d = SHN_NONE; // R4
			lo_d = CC_LO_RST; // R4
			hi_d = CC_HI_RST; // R4
		end
		st_d = st_q;
		if (en_fall) begin
			st_d = ST_RESET; // R3
		end else begin
			case (st_q)
				ST_OFF: if (en_q) st_d = ST_INIT;
				ST_INIT: if (init_done_i) st_d = ST_READY; // R7
				ST_READY: st_d = ST_READY;
				ST_RESET: if (idle_i) st_d = ST_OFF; // R5
				default: st_d = ST_OFF;
			endcase
		end
		rdy_d = st_d == ST_READY; // R6 R7
		shutdown_state_d = shutdown_state_q;
		if (en_fall) begin
			shutdown_state_d = SHUTDOWN_STATE_NORMAL; // R19
		end else if (shutdown_state_q == SHUTDOWN_STATE_NORMAL && (shn_d == SHN_NORMAL || shn_d == SHN_ABRUPT)) begin
			shutdown_state_d = SHUTDOWN_STATE_BUSY; // R13 R19
		end else if (shutdown_state_q == SHUTDOWN_STATE_BUSY && shutdown_done_i) begin
			shutdown_state_d = SHUTDOWN_STATE_DONE; // R13 R19
		end
		post_d = en_d && rdy_d; // R2
		cmd_d = post_d && !pause_i && shutdown_state_d != SHUTDOWN_STATE_DONE; // R1 R2
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			en_q <= 1'b0;
			st_q <= ST_OFF;
			rdy_q <= 1'b0;
		end else begin
			en_q <= en_d;
			st_q <= st_d;
			rdy_q <= rdy_d;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			shn_q <= SHN_NONE;
			lo_q <= CC_LO_RST;
			hi_q <= CC_HI_RST;
			shutdown_state_q <= SHUTDOWN_STATE_NORMAL;
		end else begin
			shn_q <= shn_d;
			lo_q <= lo_d;
			hi_q <= hi_d;
			shutdown_state_q <= shutdown_state_d;
		end
	end

	// admin queue sizes survive a controller reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			aqa_q <= AQA_RST;
		end else if (wr_aqa) begin
			aqa_q <= wd_new; // R4
		end
	end

	////////////////////////////////////////////////////////////////////
	// status flags
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			boot_q <= 1'b1;
			ssr_q <= 1'b0;
			cfs_q <= 1'b0;
			pp_q <= 1'b0;
		end else begin
			boot_q <= 1'b0;
			pp_q <= pause_i; // R10
			if (boot_q) begin
				ssr_q <= warm_ssr_i && !fw_activated_i; // R11
			end else if (wr_st && sel_i[0] && dat_i[ST_SSR_BIT]) begin
				ssr_q <= 1'b0;
			end
			if (fatal_err_i || (boot_q && init_fatal_i)) begin
				cfs_q <= 1'b1; // R15
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// core controls
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cmd_en_o <= 1'b0;
			post_en_o <= 1'b0;
			queue_reset_o <= 1'b0;
			flush_req_o <= 1'b0;
			shutdown_busy_o <= 1'b0;
		end else begin
			cmd_en_o <= cmd_d; // R1
			post_en_o <= post_d; // R2
			queue_reset_o <= en_fall; // R3
			flush_req_o <= st_d == ST_RESET; // R5
			shutdown_busy_o <= shutdown_state_d == SHUTDOWN_STATE_BUSY;
		end
	end

	////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_en_fall;
		$fell(en_q);
	endsequence
	sequence s_drain;
		flush_req_o && !rdy_q;
	endsequence
	sequence s_shn_req;
		wr_cc && cc_new[CC_EN_BIT] && shutdown_state_q == SHUTDOWN_STATE_NORMAL && cc_new[CC_SHN_LSB+:2] inside {SHN_NORMAL, SHN_ABRUPT};
	endsequence
	sequence s_init_wait;
		st_q == ST_INIT && !init_done_i;
	endsequence
	sequence s_drain_wait;
		st_q == ST_RESET && !idle_i;
	endsequence

	property p_ready_off;
		!en_q |-> !rdy_q && !st_word[ST_RDY_BIT];
	endproperty
	a_ready_off: assert property (p_ready_off) else $error("ready set while disabled"); // R6

	property p_reset_pulse;
		s_en_fall |-> queue_reset_o ##1 !queue_reset_o;
	endproperty
	a_reset_pulse: assert property (p_reset_pulse) else $error("no single reset pulse"); // R3

	property p_no_work_off;
		!en_q |-> !cmd_en_o && !post_en_o;
	endproperty
	a_no_work_off: assert property (p_no_work_off) else $error("work while disabled"); // R2

	property p_work_on;
		en_q && rdy_q && !pp_q && shutdown_state_q != SHUTDOWN_STATE_DONE && $past(en_q) |-> cmd_en_o;
	endproperty
	a_work_on: assert property (p_work_on) else $error("enabled and ready but idle"); // R1

	property p_ready_cause;
		$rose(rdy_q) |-> $past(st_q == ST_INIT && init_done_i && en_q);
	endproperty
	a_ready_cause: assert property (p_ready_cause) else $error("ready without init done"); // R7

	property p_drain;
		s_en_fall |-> s_drain ##1 (s_drain or st_q == ST_OFF);
	endproperty
	a_drain: assert property (p_drain) else $error("reset not held for drain"); // R5

	property p_admin_kept;
		s_en_fall |-> $stable(aqa_q);
	endproperty
	a_admin_kept: assert property (p_admin_kept) else $error("admin sizes lost on reset"); // R4

	property p_shutdown_state_legal;
		shutdown_state_q != SHUTDOWN_STATE_RSVD;
	endproperty
	a_shutdown_state_legal: assert property (p_shutdown_state_legal) else $error("bad shutdown state"); // R13

	property p_shutdown_state_done;
		$rose(shutdown_state_q == SHUTDOWN_STATE_DONE) |-> $past(shutdown_done_i);
	endproperty
	a_shutdown_state_done: assert property (p_shutdown_state_done) else $error("shutdown done without finish"); // R13 R19

	property p_fatal;
		fatal_err_i |=> cfs_q [*3];
	endproperty
	a_fatal: assert property (p_fatal) else $error("fatal flag not held"); // R15

	property p_reserved;
		ack_q && $past(off == OFF_STATUS && !we_i) |-> dat_o[31:6] == 26'h0;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved status bits set"); // R20

	property p_shutdown_state_busy;
		s_shn_req |=> shutdown_state_q == SHUTDOWN_STATE_BUSY && shutdown_busy_o;
	endproperty
	a_shutdown_state_busy: assert property (p_shutdown_state_busy) else $error("shutdown request not taken"); // R18 R19

	property p_cfg_cleared;
		s_en_fall |-> lo_q == CC_LO_RST && hi_q == CC_HI_RST && shn_q == SHN_NONE && shutdown_state_q == SHUTDOWN_STATE_NORMAL;
	endproperty
	a_cfg_cleared: assert property (p_cfg_cleared) else $error("config not cleared by reset"); // R4 R19

	property p_init_wait;
		s_init_wait |=> !rdy_q && !cmd_en_o;
	endproperty
	a_init_wait: assert property (p_init_wait) else $error("ready before init done"); // R7

	property p_drain_hold;
		s_drain_wait |=> st_q == ST_RESET && flush_req_o && !rdy_q;
	endproperty
	a_drain_hold: assert property (p_drain_hold) else $error("drain left before idle"); // R5

	property p_ssr_clear;
		wr_st && sel_i[0] && dat_i[ST_SSR_BIT] && !boot_q |=> !ssr_q;
	endproperty
	a_ssr_clear: assert property (p_ssr_clear) else $error("reset seen flag not cleared"); // R11

	property p_pause_stop;
		pp_q |-> !cmd_en_o;
	endproperty
	a_pause_stop: assert property (p_pause_stop) else $error("commands while paused"); // R10

endmodule : ces_top
`default_nettype wire

// File: verification/ces_top_tb.sv
// self-checking bench for the controller enable and status register bank
`default_nettype none
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin n_fail++; \
	$display("Error %s expected %h seen %h", n, e, s); end end
module ces_top_tb;
	import ces_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;
	logic [7:0] adr_i;
	logic [3:0] sel_i;
	logic [31:0] dat_i, dat_o, q, r, admin_queue_sizes;
	logic pause_i, fatal_err_i, shutdown_done_i, warm_ssr_i, init_done_i, idle_i, init_fatal_i, fw_activated_i;
	logic cmd_en_o, post_en_o, queue_reset_o, flush_req_o, shutdown_busy_o;
	int n_fail, checks_done, n_qr, qr0;
	ces_top ces_top_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .init_done_i(init_done_i),
		.idle_i(idle_i), .pause_i(pause_i), .fatal_err_i(fatal_err_i), .init_fatal_i(init_fatal_i),
		.warm_ssr_i(warm_ssr_i), .fw_activated_i(fw_activated_i), .shutdown_done_i(shutdown_done_i),
		.cmd_en_o(cmd_en_o), .post_en_o(post_en_o), .queue_reset_o(queue_reset_o),
		.flush_req_o(flush_req_o), .shutdown_busy_o(shutdown_busy_o));
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	// counts cycles in which the queue reset pulse is high
	always @(posedge clk_i) begin
		if (queue_reset_o === 1'b1) n_qr++;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	// request held until ack is seen at a rising edge, then one idle cycle
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		sel_i <= 4'hf;
		do begin
			@(posedge clk_i);
		end while (ack_o !== 1'b1);
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
		@(posedge clk_i);
	endtask : bus
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0000_0000);
		`CHK("read data", e, q)
	endtask : rd_chk
	task automatic end_sim;
		if (n_fail == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : end_sim
	initial begin
		repeat (5000) @(posedge clk_i);
		n_fail++;
		end_sim();
	end
	initial begin
		rst_i = 1'b1;
		cyc_i = 1'b0;
		stb_i = 1'b0;
		we_i = 1'b0;
		adr_i = 8'h00;
		sel_i = 4'h0;
		dat_i = 32'h0000_0000;
		pause_i = 1'b0;
		fatal_err_i = 1'b0;
		shutdown_done_i = 1'b0;
		warm_ssr_i = 1'b1;
		init_done_i = 1'b0;
		idle_i = 1'b1;
		init_fatal_i = 1'b0;
		fw_activated_i = 1'b0;
		n_fail = 0;
		checks_done = 0;
		n_qr = 0;
		r = 32'h0000_ff67;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		rd_chk(OFF_STATUS, 32'h0000_0010);
		bus(1'b1, OFF_STATUS, 32'hffff_ffff);
		rd_chk(OFF_STATUS, 32'h0000_0000);
		`CHK("cmd enable off", 1'b0, cmd_en_o)
		for (int i = 0; i < 4; i++) begin
			r = lfsr(r);
			admin_queue_sizes = r;
			bus(1'b1, OFF_ADMIN_SIZES, admin_queue_sizes);
			rd_chk(OFF_ADMIN_SIZES, admin_queue_sizes & AQA_MASK);
			r = lfsr(r);
			bus(1'b1, OFF_CONFIG, r & 32'h00ff_3ff0);
			rd_chk(OFF_CONFIG, r & 32'h00ff_3ff0);
		end
		bus(1'b1, 8'h40, r);
		rd_chk(8'h40, 32'h0000_0000);
		bus(1'b1, OFF_CONFIG, 32'h0000_0001);
		repeat (4) @(posedge clk_i);
		rd_chk(OFF_STATUS, 32'h0000_0000);
		`CHK("cmd enable before ready", 1'b0, cmd_en_o)
		@(posedge clk_i) init_done_i <= 1'b1;
		rd_chk(OFF_STATUS, 32'h0000_0001);
		`CHK("cmd enable", 1'b1, cmd_en_o)
		`CHK("post enable", 1'b1, post_en_o)
		@(posedge clk_i) pause_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rd_chk(OFF_STATUS, 32'h0000_0021);
		`CHK("cmd enable paused", 1'b0, cmd_en_o)
		@(posedge clk_i) pause_i <= 1'b0;
		bus(1'b1, OFF_CONFIG, 32'h0000_4001);
		`CHK("shutdown busy", 1'b1, shutdown_busy_o)
		rd_chk(OFF_STATUS, 32'h0000_0005);
		@(posedge clk_i) shutdown_done_i <= 1'b1;
		@(posedge clk_i) shutdown_done_i <= 1'b0;
		rd_chk(OFF_STATUS, 32'h0000_0009);
		`CHK("cmd enable shut down", 1'b0, cmd_en_o)
		@(posedge clk_i) fatal_err_i <= 1'b1;
		@(posedge clk_i) fatal_err_i <= 1'b0;
		rd_chk(OFF_STATUS, 32'h0000_000b);
		qr0 = n_qr;
		@(posedge clk_i) idle_i <= 1'b0;
		bus(1'b1, OFF_CONFIG, 32'h0012_3450);
		`CHK("cmd enable cleared", 1'b0, cmd_en_o)
		`CHK("post enable cleared", 1'b0, post_en_o)
		`CHK("flush request", 1'b1, flush_req_o)
		rd_chk(OFF_STATUS, 32'h0000_0002);
		`CHK("flush held", 1'b1, flush_req_o)
		`CHK("queue reset pulses", 1, n_qr - qr0)
		@(posedge clk_i) idle_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		`CHK("flush ended", 1'b0, flush_req_o)
		rd_chk(OFF_CONFIG, 32'h0000_0000);
		rd_chk(OFF_ADMIN_SIZES, admin_queue_sizes & AQA_MASK);
		bus(1'b1, OFF_CONFIG, 32'h0000_0001);
		repeat (4) @(posedge clk_i);
		rd_chk(OFF_STATUS, 32'h0000_0003);
		// second reset in mid-run with other straps
		@(posedge clk_i) begin
			rst_i <= 1'b1;
			init_fatal_i <= 1'b1;
			fw_activated_i <= 1'b1;
		end
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		`CHK("cmd enable after reset", 1'b0, cmd_en_o)
		rd_chk(OFF_STATUS, 32'h0000_0002);
		end_sim();
	end
endmodule : ces_top_tb
`default_nettype wire
